// [verilog/pair_expander_defines.vh]
/*
 * constants of the paired-register two-wire slave: command codes, register
 * reset values and sampling details.
 * assumes inclusion by bare name from the design files.
 */
`ifndef PAIR_EXPANDER_DEFINES_VH
`define PAIR_EXPANDER_DEFINES_VH

// ---------------------------------------------------------------
// command codes (register index)
// ---------------------------------------------------------------
`define CMD_INPUT0     3'h0
`define CMD_INPUT1     3'h1
`define CMD_OUTPUT0    3'h2
`define CMD_OUTPUT1    3'h3
`define CMD_POLARITY0  3'h4
`define CMD_POLARITY1  3'h5
`define CMD_CONFIG0    3'h6
`define CMD_CONFIG1    3'h7

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define RST_OUTPUT     8'hFF
`define RST_POLARITY   8'h00
`define RST_CONFIG     8'hFF
`define RST_POINTER    3'h0

// ---------------------------------------------------------------
// bus details
// ---------------------------------------------------------------
`define DEV_ADDR_BITS  7
`define BIT_COUNT_ACK  4'h8
`define SYNC_STAGES    3
`define SNAP_SETTLE    3'h7

`endif

// [verilog/pin_sync3.v]
/*
 * three-flop synchroniser for one pin; the output changes only once the
 * second and third stages agree.
 * assumes a single system clock and an async active-low reset.
 */
module pin_sync3 #(
  parameter       RESET_LEVEL = 1'b1
) (
  input  wire     i_clk_sys,
  input  wire     i_rstn,
  input  wire     i_pin,
  output reg      o_level
);

  reg  s1_q;
  reg  s2_q;
  reg  s3_q;

  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      s1_q    <= RESET_LEVEL;
      s2_q    <= RESET_LEVEL;
      s3_q    <= RESET_LEVEL;
      o_level <= RESET_LEVEL;
    end else begin
      s1_q <= i_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        o_level <= s3_q;
      end
    end
  end

endmodule

// [verilog/pair_expander_slave.v]
/*
 * two-wire bus slave with eight byte registers in four pairs: input,
 * output, polarity inversion and direction. the pointer is loaded by the
 * command byte and toggles within its pair after every data byte.
 * assumes scl and sda arrive asynchronously and are oversampled by the
 * system clock (25 MHz against at most 400 kHz bus clock); sda is open
 * drain, driven low while o_sda_oe is high. i_rstn is the power-on reset.
 */
`include "pair_expander_defines.vh"

// How it works
// - command byte loads the register pointer
// - pointer toggles within pair after each byte
// - unlimited write bytes, stays inside pair
// - read sends pointer-selected register first
// - further read bytes alternate within pair
// - pointer persists across start and restart
// - read data captured at acknowledge rising edge
// - stop anywhere; acked data stays valid
// - read without command uses stored pointer
// - reset restores registers and bus machine
// - input port registers ignore writes
// - output registers read back written value
// - reading either input port clears the one shared interrupt
// - command codes map to four register pairs
module pair_expander_slave #(
  parameter [6:0] DEV_ADDR = 7'h20
) (
  input  wire        i_clk_sys,
  input  wire        i_rstn,
  input  wire        i_scl,
  input  wire        i_sda,
  output wire        o_sda_out,
  output wire        o_sda_oe,
  input  wire [15:0] i_port_in,
  output wire [15:0] o_port_out,
  output wire [15:0] o_port_dir,
  output wire [15:0] o_port_pol,
  output wire        o_int_n
);

  // ---------------------------------------------------------------
  // states
  // ---------------------------------------------------------------
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_ADDR  = 3'h1;
  localparam [2:0] ST_CMD   = 3'h2;
  localparam [2:0] ST_WDATA = 3'h3;
  localparam [2:0] ST_RDATA = 3'h4;
  localparam [2:0] ST_MACK  = 3'h5;

  // ---------------------------------------------------------------
  // synchronised bus lines and edges
  // ---------------------------------------------------------------
  wire scl_s;
  wire sda_s;
  reg  scl_prev_q;
  reg  sda_prev_q;

  pin_sync3 #(.RESET_LEVEL(1'b1)) u_sync_scl (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .i_pin     (i_scl),
    .o_level   (scl_s)
  );

  pin_sync3 #(.RESET_LEVEL(1'b1)) u_sync_sda (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .i_pin     (i_sda),
    .o_level   (sda_s)
  );

  // ---------------------------------------------------------------
  // synchronised port pins
  // ---------------------------------------------------------------
  wire [15:0] port_s;

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_port_sync
      pin_sync3 #(.RESET_LEVEL(1'b1)) u_sync_port (
        .i_clk_sys (i_clk_sys),
        .i_rstn    (i_rstn),
        .i_pin     (i_port_in[gi]),
        .o_level   (port_s[gi])
      );
    end
  endgenerate

  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_prev_q;
  wire scl_fall = ~scl_s & scl_prev_q;
  wire start_c  = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  wire stop_c   = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg  [2:0]  state_q;
  reg  [3:0]  bit_cnt_q;
  reg  [7:0]  shift_q;
  reg  [2:0]  ptr_q;
  reg         rw_q;
  reg         ack_phase_q;
  reg         sda_low_q;
  reg  [7:0]  tx_q;
  reg  [7:0]  out0_q;
  reg  [7:0]  out1_q;
  reg  [7:0]  pol0_q;
  reg  [7:0]  pol1_q;
  reg  [7:0]  cfg0_q;
  reg  [7:0]  cfg1_q;
  reg  [15:0] in_snap_q;
  reg         int_q;
  reg  [2:0]  snap_wait_q;

  // input register view: pin level xor polarity
  wire [15:0] in_view = port_s ^ {pol1_q, pol0_q};

  reg  [7:0]  rd_mux;
  always @* begin
    case (ptr_q)
      `CMD_INPUT0:    rd_mux = in_view[7:0];
      `CMD_INPUT1:    rd_mux = in_view[15:8];
      `CMD_OUTPUT0:   rd_mux = out0_q;
      `CMD_OUTPUT1:   rd_mux = out1_q;
      `CMD_POLARITY0: rd_mux = pol0_q;
      `CMD_POLARITY1: rd_mux = pol1_q;
      `CMD_CONFIG0:   rd_mux = cfg0_q;
      `CMD_CONFIG1:   rd_mux = cfg1_q;
      default:        rd_mux = 8'h00;
    endcase
  end

  wire [7:0] rx_byte  = {shift_q[6:0], sda_s};
  wire [2:0] ptr_pair = {ptr_q[2:1], ~ptr_q[0]};

  // byte for the register the pointer toggles to
  reg  [7:0] rd_mux_next;
  always @* begin
    case (ptr_pair)
      `CMD_INPUT0:    rd_mux_next = in_view[7:0];
      `CMD_INPUT1:    rd_mux_next = in_view[15:8];
      `CMD_OUTPUT0:   rd_mux_next = out0_q;
      `CMD_OUTPUT1:   rd_mux_next = out1_q;
      `CMD_POLARITY0: rd_mux_next = pol0_q;
      `CMD_POLARITY1: rd_mux_next = pol1_q;
      `CMD_CONFIG0:   rd_mux_next = cfg0_q;
      `CMD_CONFIG1:   rd_mux_next = cfg1_q;
      default:        rd_mux_next = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // bus state machine
  // ---------------------------------------------------------------
  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q     <= ST_IDLE;
      bit_cnt_q   <= 4'h0;
      shift_q     <= 8'h00;
      ptr_q       <= `RST_POINTER;
      rw_q        <= 1'b0;
      ack_phase_q <= 1'b0;
      sda_low_q   <= 1'b0;
      tx_q        <= 8'h00;
      out0_q      <= `RST_OUTPUT;
      out1_q      <= `RST_OUTPUT;
      pol0_q      <= `RST_POLARITY;
      pol1_q      <= `RST_POLARITY;
      cfg0_q      <= `RST_CONFIG;
      cfg1_q      <= `RST_CONFIG;
    end else if (stop_c) begin
      state_q     <= ST_IDLE;
      ack_phase_q <= 1'b0;
      sda_low_q   <= 1'b0;
    end else if (start_c) begin
      state_q     <= ST_ADDR;
      bit_cnt_q   <= 4'h0;
      ack_phase_q <= 1'b0;
      sda_low_q   <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          sda_low_q <= 1'b0;
        end
        ST_ADDR, ST_CMD, ST_WDATA: begin
          if (scl_rise && !ack_phase_q) begin
            shift_q   <= rx_byte;
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
          if (scl_fall && !ack_phase_q && bit_cnt_q == `BIT_COUNT_ACK) begin
            ack_phase_q <= 1'b1;
            bit_cnt_q   <= 4'h0;
            if (state_q == ST_ADDR) begin
              if (shift_q[7:1] == DEV_ADDR) begin
                sda_low_q <= 1'b1;
                rw_q      <= shift_q[0];
              end else begin
                state_q <= ST_IDLE;
              end
            end else if (state_q == ST_CMD) begin
              ptr_q     <= shift_q[2:0];
              sda_low_q <= 1'b1;
            end else begin
              sda_low_q <= 1'b1;
              case (ptr_q)
                `CMD_OUTPUT0:   out0_q <= shift_q;
                `CMD_OUTPUT1:   out1_q <= shift_q;
                `CMD_POLARITY0: pol0_q <= shift_q;
                `CMD_POLARITY1: pol1_q <= shift_q;
                `CMD_CONFIG0:   cfg0_q <= shift_q;
                `CMD_CONFIG1:   cfg1_q <= shift_q;
                default:        ;
              endcase
              ptr_q <= ptr_pair;
            end
          end else if (scl_fall && ack_phase_q) begin
            // end of our acknowledge bit
            ack_phase_q <= 1'b0;
            sda_low_q   <= 1'b0;
            if (state_q == ST_ADDR && rw_q) begin
              state_q   <= ST_RDATA;
              sda_low_q <= ~tx_q[7];
              bit_cnt_q <= 4'h1;
            end else if (state_q == ST_ADDR) begin
              state_q <= ST_CMD;
            end else begin
              state_q <= ST_WDATA;
            end
          end
          // load first read byte while address ack is driven
          if (state_q == ST_ADDR && scl_rise && ack_phase_q) begin
            tx_q <= rd_mux;
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (bit_cnt_q == `BIT_COUNT_ACK) begin
              state_q   <= ST_MACK;
              sda_low_q <= 1'b0;
              bit_cnt_q <= 4'h0;
            end else begin
              sda_low_q <= ~tx_q[3'h7 - bit_cnt_q[2:0]];
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            ptr_q <= ptr_pair;
            if (sda_s) begin
              state_q <= ST_IDLE;
            end else begin
              tx_q <= rd_mux_next;
            end
          end else if (scl_fall) begin
            state_q   <= ST_RDATA;
            sda_low_q <= ~tx_q[7];
            bit_cnt_q <= 4'h1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // port change interrupt
  // ---------------------------------------------------------------
  wire [15:0] in_mask  = {cfg1_q, cfg0_q};
  wire        in_diff  = |((port_s ^ in_snap_q) & in_mask);
  wire        rd_ack   = (state_q == ST_MACK) && scl_rise;
  wire        rd_port  = rd_ack && (ptr_q[2:1] == 2'b00);

  // track the pins until the synchronisers settle, so reset raises no
  // false interrupt
  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      in_snap_q   <= 16'h0000;
      int_q       <= 1'b0;
      snap_wait_q <= `SNAP_SETTLE;
    end else if (snap_wait_q != 3'h0 || rd_port) begin
      in_snap_q <= port_s;
      int_q     <= 1'b0;
      if (snap_wait_q != 3'h0) begin
        snap_wait_q <= snap_wait_q - 3'h1;
      end
    end else begin
      int_q <= in_diff;
    end
  end

  assign o_sda_out  = 1'b0;
  assign o_sda_oe   = sda_low_q;
  assign o_port_out = {out1_q, out0_q};
  assign o_port_dir = {cfg1_q, cfg0_q};
  assign o_port_pol = {pol1_q, pol0_q};
  assign o_int_n    = ~int_q;

endmodule

// [sim/pair_slave_monitor.sv]
/* port checker of the paired-register two-wire slave.
   assumes it is bound to the slave top; one clock, async low reset. */
module pair_slave_monitor (
  input wire        i_clk_sys,
  input wire        i_rstn,
  input wire        o_sda_out,
  input wire        o_sda_oe,
  input wire [15:0] o_port_out,
  input wire [15:0] o_port_dir,
  input wire [15:0] o_port_pol,
  input wire        o_int_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] idle_q;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  // --------------------------------------------
  // cycles since the slave last pulled sda low
  // --------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rstn)
    if (!i_rstn) idle_q <= 4'hF;
    else if (o_sda_oe) idle_q <= 4'h0;
    else if (idle_q != 4'hF) idle_q <= idle_q + 4'h1;
  a_reset_regs: assert property (
    $rose(i_rstn) |-> o_port_out == 16'hFFFF && o_port_dir == 16'hFFFF
      && o_port_pol == 16'h0000) else $error("regs off reset values");
  a_reset_quiet: assert property (
    $rose(i_rstn) |-> (!o_sda_oe)[*3]) else $error("sda pulled at reset");
  a_drive_low: assert property (
    o_sda_oe |-> o_sda_out == 1'b0) else $error("sda driven high");
  a_ack_stands: assert property (
    $rose(o_sda_oe) |=> o_sda_oe[*3]) else $error("sda low too short");
  a_out_at_ack: assert property (
    !$stable(o_port_out) |-> (idle_q < 4'h4) or (##[0:3] o_sda_oe))
    else $error("output reg moved off ack");
  a_pol_at_ack: assert property (
    !$stable(o_port_pol) |-> (idle_q < 4'h4) or (##[0:3] o_sda_oe))
    else $error("polarity reg moved off ack");
  a_dir_at_ack: assert property (
    !$stable(o_port_dir) |-> (idle_q < 4'h4) or (##[0:3] o_sda_oe))
    else $error("direction reg moved off ack");
  a_output_no_int: assert property (
    (o_port_dir == 16'h0000)[*4] |-> !$fell(o_int_n))
    else $error("interrupt from output pins");
endmodule

bind pair_expander_slave pair_slave_monitor i_mon (
  .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .o_sda_out(o_sda_out),
  .o_sda_oe(o_sda_oe), .o_port_out(o_port_out), .o_port_dir(o_port_dir),
  .o_port_pol(o_port_pol), .o_int_n(o_int_n));

// [sim/bus_master_model.sv]
/* two-wire bus master model: drives scl and its own pull on sda.
   assumes the bench wires sda as a pulled-up wired-and line. */
module bus_master_model (
  input  wire  i_clk,
  input  wire  i_sda,
  output logic o_scl,
  output logic o_sda_m
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_scl = 1'b1;
    o_sda_m = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // sda moves one clock after scl falls, so the slave never sees a false
  // start or stop; sampled at the end of the high phase
  task automatic bit_io(input logic b, output logic r);
    tick(1);
    o_sda_m <= b;
    tick(5);
    o_scl <= 1'b1;
    tick(2);
    r = i_sda;
    o_scl <= 1'b0;
  endtask
  task automatic start;
    tick(1);
    o_sda_m <= 1'b1;
    tick(5);
    o_scl <= 1'b1;
    tick(4);
    o_sda_m <= 1'b0;
    tick(4);
    o_scl <= 1'b0;
  endtask
  task automatic stop;
    tick(1);
    o_sda_m <= 1'b0;
    tick(5);
    o_scl <= 1'b1;
    tick(4);
    o_sda_m <= 1'b1;
    tick(8);
  endtask
  task automatic wb(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic rb(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(nack, r);
  endtask
endmodule

// [sim/testbench.sv]
/* self-checking bench of the paired-register slave.
   assumes the master model drives the bus; slave at address 7'h20. */
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [6:0] ADR = 7'h20;
  logic        clk, rstn, ack;
  logic [15:0] pins;
  logic [31:0] lfsr = 32'h3130B682;
  logic [7:0]  regs [0:7];
  logic [7:0]  d;
  logic [2:0]  ptr;
  int          fails, tests_run;
  wire         scl, sda_m, sda_oe, sda_out, int_n;
  wire  [15:0] pout, pdir, ppol;
  wire         sda = (sda_oe ? sda_out : 1'b1) & sda_m;
  pair_expander_slave #(.DEV_ADDR(ADR)) i_dut (.i_clk_sys(clk),
    .i_rstn(rstn), .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out),
    .o_sda_oe(sda_oe), .i_port_in(pins), .o_port_out(pout),
    .o_port_dir(pdir), .o_port_pol(ppol), .o_int_n(int_n));
  bus_master_model i_mst (.i_clk(clk), .i_sda(sda), .o_scl(scl),
    .o_sda_m(sda_m));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ----------------------
  // expectations and checks
  // ----------------------
  function automatic logic [7:0] rnd8();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction
  function automatic logic [7:0] exp_byte(input logic [2:0] p);
    return p == 3'h0 ? pins[7:0] ^ regs[4] :
           p == 3'h1 ? pins[15:8] ^ regs[5] : regs[p];
  endfunction
  task automatic chk(input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic send(input logic [7:0] b);
    i_mst.wb(b, ack);
    chk(16'h0001, {15'h0, ack});
  endtask
  task automatic wr(input logic [2:0] c, input int n, input logic [7:0] v);
    i_mst.start();
    send({ADR, 1'b0});
    send({5'h0, c});
    ptr = c;
    repeat (n) begin
      d = (v == 8'h5A) ? rnd8() : v;
      send(d);
      if (ptr > 3'h1) regs[ptr] = d;
      ptr ^= 3'h1;
    end
    i_mst.stop();
    chk({regs[3], regs[2]}, pout);
    chk({regs[5], regs[4]}, ppol);
    chk({regs[7], regs[6]}, pdir);
  endtask
  task automatic rd(input logic [2:0] c, input logic setp, input int n);
    if (setp) begin
      i_mst.start();
      send({ADR, 1'b0});
      send({5'h0, c});
      ptr = c;
    end
    i_mst.start();
    send({ADR, 1'b1});
    for (int i = 1; i <= n; i++) begin
      i_mst.rb(i == n, d);
      chk({8'h0, exp_byte(ptr)}, {8'h0, d});
      ptr ^= 3'h1;
    end
    i_mst.stop();
  endtask
  task automatic results;
    $display("compares %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #1000000;
    fails++;
    results();
  end
  // ----------------------
  // main sequence
  // ----------------------
  initial begin
    rstn = 1'b0;
    pins = 16'h3C96;
    fails = 0;
    tests_run = 0;
    foreach (regs[i]) regs[i] = (i == 4 || i == 5) ? 8'h00 : 8'hFF;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (8) @(posedge clk);
    chk(16'hFFFF, pout);
    chk(16'hFFFF, pdir);
    chk(16'h0000, ppol);
    $display("test reset done");
    for (int c = 1; c < 8; c++) wr(3'(c), 3, 8'h5A);
    for (int c = 2; c < 8; c++) rd(3'(c), 1'b1, 3);
    rd(3'h1, 1'b1, 1);
    rd(ptr, 1'b0, 1);
    i_mst.start();
    i_mst.wb({ADR ^ 7'h01, 1'b0}, ack);
    chk(16'h0000, {15'h0, ack});
    i_mst.stop();
    i_mst.start();
    send({ADR, 1'b0});
    send(8'h02);
    d = rnd8();
    send(d);
    regs[2] = d;
    for (int i = 0; i < 5; i++) i_mst.bit_io(1'b1, ack);
    i_mst.stop();
    chk({regs[3], regs[2]}, pout);
    $display("test pairs done");
    wr(3'h4, 2, 8'h00);
    wr(3'h6, 2, 8'h00);
    rd(3'h0, 1'b1, 2);
    pins <= {rnd8(), rnd8()};
    repeat (20) @(posedge clk);
    chk(16'h0001, {15'h0, int_n});
    wr(3'h6, 2, 8'hFF);
    rd(3'h0, 1'b1, 2);
    rd(ptr, 1'b0, 1);
    pins <= pins ^ 16'h0011;
    for (int i = 0; i < 20 && int_n !== 1'b0; i++) @(posedge clk);
    chk(16'h0000, {15'h0, int_n});
    rd(3'h0, 1'b1, 1);
    chk(16'h0001, {15'h0, int_n});
    $display("test interrupt done");
    results();
  end
endmodule
